// File: src/tcc_pkg.sv
/*
  Constants, field layouts, encodings and the register state record of
  the capture/compare timer channel. Assumes a 32-bit Avalon-MM slave
  with byte addresses and a 100 MHz system clock.
*/
// Summary of operation
// RULE1: A 16-bit up-counter can be copied into a capture register on a chosen edge without disturbing the count.
// RULE2: With the prescaled clock and rising-edge capture selected, each rise of capture input 0 latches the counter into capture register 0.
// RULE3: Capture edge code 11 latches the counter into capture register 0 on the rise and into capture register 1 on the fall of the companion flip-flop.
// RULE4: The counter may instead be clocked by the rising edges of capture input 0, counting them as events.
// RULE5: In pulse-width setup, a rise of capture input 0 latches capture register 0 and a fall latches capture register 1.
// RULE6: In time-difference setup, a rise of capture input 1 latches capture register 1 independently of capture input 0.
// RULE7: Each capture register raises its own capture interrupt when a value is latched into it.
// RULE8: Two enable bits let the output flip-flop invert on a match with compare register 0 and on a match with compare register 1.
// RULE9: With the compare register 1 enable set, the output flip-flop inverts when the counter equals compare register 1.
// RULE10: With its enable set, the output flip-flop inverts when a value is captured into capture register 0.
// RULE11: Writing the flip-flop control with both match enables clear and the clear code stops toggling and forces the flip-flop to 0.
// RULE12: Clearing both match enables stops any further inversion on compare matches.
// RULE13: A mask bit per match or overflow source keeps masked sources off the timer interrupt.
// RULE14: Setting the count run bit and the prescaler run bit starts the counter, clearing both stops it.
// RULE15: Software must write compare register 1 before the counter reaches that value, or the match is missed.
// RULE16: While the channel enable bit is 0 all counting, capturing and register updates are held off; status reads still clear status bits.
// RULE17: A free-running counter wraps from its 16-bit maximum to zero and goes on counting.
package tcc_pkg;

  localparam int CNT_W  = 16;
  localparam int REG_W  = 32;
  localparam int ADDR_W = 6;
  localparam int BE_W   = 4;
  localparam int BYTE_W = 8;
  localparam int PRE_W  = 8;
  localparam int ST_W   = 5;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RUN    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_FFCR   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CMP0   = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CMP1   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CAP0   = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CAP1   = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h28;

  // Field positions.
  localparam int EN_BIT       = 0;
  localparam int RUN_CNT_BIT  = 0;
  localparam int RUN_PRE_BIT  = 2;
  localparam int CLK_LSB      = 0;
  localparam int CAP_LSB      = 3;
  localparam int SEL_W        = 2;
  localparam int FF_CTRL_LSB  = 0;
  localparam int FF_EN_LSB    = 2;
  localparam int FF_EN_W      = 4;
  localparam int FF_STATE_BIT = 6;
  localparam int EN_M0        = 0;
  localparam int EN_M1        = 1;
  localparam int EN_C0        = 2;
  localparam int EN_C1        = 3;
  localparam int ST_M0        = 0;
  localparam int ST_M1        = 1;
  localparam int ST_OVF       = 2;
  localparam int ST_C0        = 3;
  localparam int ST_C1        = 4;

  // Prescaler taps: divide by two to the power of the shift.
  localparam int PT1_SHIFT = 1;
  localparam int PT2_SHIFT = 3;
  localparam int PT3_SHIFT = 5;

  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_STEP = 8'h01;
  localparam logic [ST_W-1:0]  MASK_RST = 5'h1F;

  typedef enum logic [1:0] {CLK_EXT, CLK_PT1, CLK_PT2, CLK_PT3} tcc_clksel_t;
  typedef enum logic [1:0] {
    CAP_OFF, CAP_RISE_BOTH, CAP_IN0_PULSE, CAP_COMPANION
  } tcc_capmode_t;
  typedef enum logic [1:0] {FF_INVERT, FF_SET, FF_CLEAR, FF_KEEP} tcc_ffctl_t;

  typedef struct packed {
    logic                 enable;
    logic                 run_cnt;
    logic                 run_pre;
    tcc_clksel_t          clksel;
    tcc_capmode_t         capmode;
    logic [FF_EN_W-1:0]   ff_en;
    logic [ST_W-1:0]      mask;
    logic [ST_W-1:0]      status;
    logic [CNT_W-1:0]     cmp0;
    logic [CNT_W-1:0]     cmp1;
    logic [CNT_W-1:0]     cap0;
    logic [CNT_W-1:0]     cap1;
    logic [CNT_W-1:0]     count;
    logic                 ff;
    logic [PRE_W-1:0]     pre;
  } tcc_regs_t;

  localparam tcc_regs_t REGS_RST = '{
    clksel: CLK_EXT, capmode: CAP_OFF, mask: MASK_RST, default: '0};

endpackage

// File: src/tcc_edge_det.sv
/*
  Rise and fall detector for one input of the timer channel.
  Assumes the input is already synchronous to sys_clk.
*/
`timescale 1ns/10ps
module tcc_edge_det (
  input  wire logic sys_clk,   // System clock.
  input  wire logic sys_rst,   // Synchronous reset, active high.
  input  wire logic sig_in,    // Level to watch.
  output logic      rise,      // High for one cycle after a rise.
  output logic      fall       // High for one cycle after a fall.
);
  logic prev_reg;
  logic prev_next;

  // Edges compare the live level with last cycle's level.
  always_comb begin
    prev_next = sig_in;
    rise      = sig_in & ~prev_reg;
    fall      = ~sig_in & prev_reg;
  end

  // Reset to low so a high input at release shows as one rise.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule

// File: src/tcc_timer.sv
/*
  Capture/compare timer channel: 16-bit up-counter, prescaler, two
  capture and two compare registers, output toggle flip-flop, sticky
  status with mask, and an Avalon-MM slave with waitrequest.
  Assumes all pin inputs are synchronous to sys_clk and that the bus
  master holds each request until it sees waitrequest low.
*/
`timescale 1ns/10ps
module tcc_timer #(
  parameter int PT1_SHIFT = tcc_pkg::PT1_SHIFT, // Prescaled clock 1 tap.
  parameter int PT2_SHIFT = tcc_pkg::PT2_SHIFT, // Prescaled clock 2 tap.
  parameter int PT3_SHIFT = tcc_pkg::PT3_SHIFT  // Prescaled clock 3 tap.
) (
  input  wire logic                       sys_clk,         // 100 MHz.
  input  wire logic                       sys_rst,         // Sync, high.
  input  wire logic [tcc_pkg::ADDR_W-1:0] avs_address,     // Byte address.
  input  wire logic                       avs_read,        // Read strobe.
  input  wire logic                       avs_write,       // Write strobe.
  input  wire logic [tcc_pkg::REG_W-1:0]  avs_writedata,   // Write data.
  input  wire logic [tcc_pkg::BE_W-1:0]   avs_byteenable,  // Byte lanes.
  output logic      [tcc_pkg::REG_W-1:0]  avs_readdata,    // Read data.
  output logic                            avs_waitrequest, // Stall.
  input  wire logic                       capture_input0,  // Capture pin 0.
  input  wire logic                       capture_input1,  // Capture pin 1.
  input  wire logic                       companion_ff_in, // Other timer FF.
  output logic                            timer_output_pin, // Toggle FF.
  output logic                            match_irq,       // Match/overflow.
  output logic                            capture0_irq,    // Capture 0.
  output logic                            capture1_irq,    // Capture 1.
  output logic                            irq              // Any unmasked.
);
  tcc_pkg::tcc_regs_t             state_reg;
  tcc_pkg::tcc_regs_t             state_next;
  logic                           ack_reg;
  logic                           ack_next;
  logic [tcc_pkg::REG_W-1:0]      rdata_reg;
  logic [tcc_pkg::REG_W-1:0]      rdata_next;
  logic [tcc_pkg::REG_W-1:0]      rd_mux;
  logic [tcc_pkg::REG_W-1:0]      wmerge;
  logic [tcc_pkg::ST_W-1:0]       events;
  logic [tcc_pkg::ST_W-1:0]       st_clr;
  logic [tcc_pkg::CNT_W-1:0]      cnt_inc;
  logic                           in0_rise;
  logic                           in0_fall;
  logic                           in1_rise;
  logic                           comp_rise;
  logic                           comp_fall;
  logic                           pre_run;
  logic                           cnt_src;
  logic                           cnt_tick;
  logic                           cap0_ev;
  logic                           cap1_ev;
  logic                           m0_ev;
  logic                           m1_ev;
  logic                           ovf_ev;
  logic                           toggle_req;
  logic                           req;
  logic                           wr_ok;
  logic                           rd_ok;
  logic                           ff_wr;
  tcc_pkg::tcc_ffctl_t            ff_ctl;

  // Merge the enabled byte lanes of new data over the old value.
  function automatic logic [tcc_pkg::REG_W-1:0] be_merge(
    input logic [tcc_pkg::REG_W-1:0] old_v,
    input logic [tcc_pkg::REG_W-1:0] new_v,
    input logic [tcc_pkg::BE_W-1:0]  be
  );
    logic [tcc_pkg::REG_W-1:0] res;
    res = old_v;
    for (int i = 0; i < tcc_pkg::BE_W; i++) begin
      if (be[i]) begin
        res[i*tcc_pkg::BYTE_W +: tcc_pkg::BYTE_W] =
          new_v[i*tcc_pkg::BYTE_W +: tcc_pkg::BYTE_W];
      end
    end
    return res;
  endfunction

  // Edge detectors on the capture pins and the companion flip-flop.
  tcc_edge_det u_edge_in0 (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (capture_input0),
    .rise    (in0_rise),
    .fall    (in0_fall)
  );
  tcc_edge_det u_edge_in1 (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (capture_input1),
    .rise    (in1_rise),
    .fall    ()
  );
  tcc_edge_det u_edge_comp (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (companion_ff_in),
    .rise    (comp_rise),
    .fall    (comp_fall)
  );

  // Bus handshake: one wait cycle per access, so read data are already
  // registered when waitrequest drops and the clear-on-read of status
  // only removes the bits that were actually returned.
  always_comb begin
    req             = avs_read | avs_write;
    avs_waitrequest = req & ~ack_reg;
    ack_next        = req & ~ack_reg;
    rdata_next      = (avs_read & ~ack_reg) ? rd_mux : rdata_reg;
    rd_ok           = avs_read & ack_reg;
    wr_ok           = avs_write & ack_reg &
                      (state_reg.enable |
                       (avs_address == tcc_pkg::OFS_ENABLE)); // RULE16
    ff_wr           = wr_ok & avs_byteenable[0] &
                      (avs_address == tcc_pkg::OFS_FFCR);
    wmerge          = be_merge(rd_mux, avs_writedata, avs_byteenable);
    ff_ctl          = tcc_pkg::tcc_ffctl_t'(
                        wmerge[tcc_pkg::FF_CTRL_LSB +: tcc_pkg::SEL_W]);
    avs_readdata    = rdata_reg;
  end

  // Read multiplexer; unmapped offsets and unused bits read as zero.
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      tcc_pkg::OFS_ENABLE: rd_mux[tcc_pkg::EN_BIT] = state_reg.enable;
      tcc_pkg::OFS_RUN: begin
        rd_mux[tcc_pkg::RUN_CNT_BIT] = state_reg.run_cnt;
        rd_mux[tcc_pkg::RUN_PRE_BIT] = state_reg.run_pre;
      end
      tcc_pkg::OFS_MODE: begin
        rd_mux[tcc_pkg::CLK_LSB +: tcc_pkg::SEL_W] = state_reg.clksel;
        rd_mux[tcc_pkg::CAP_LSB +: tcc_pkg::SEL_W] = state_reg.capmode;
      end
      tcc_pkg::OFS_FFCR: begin
        rd_mux[tcc_pkg::FF_CTRL_LSB +: tcc_pkg::SEL_W] = tcc_pkg::FF_KEEP;
        rd_mux[tcc_pkg::FF_EN_LSB +: tcc_pkg::FF_EN_W] = state_reg.ff_en;
        rd_mux[tcc_pkg::FF_STATE_BIT] = state_reg.ff;
      end
      tcc_pkg::OFS_STATUS: rd_mux[tcc_pkg::ST_W-1:0] = state_reg.status;
      tcc_pkg::OFS_MASK:   rd_mux[tcc_pkg::ST_W-1:0] = state_reg.mask;
      tcc_pkg::OFS_CMP0:   rd_mux[tcc_pkg::CNT_W-1:0] = state_reg.cmp0;
      tcc_pkg::OFS_CMP1:   rd_mux[tcc_pkg::CNT_W-1:0] = state_reg.cmp1;
      tcc_pkg::OFS_CAP0:   rd_mux[tcc_pkg::CNT_W-1:0] = state_reg.cap0;
      tcc_pkg::OFS_CAP1:   rd_mux[tcc_pkg::CNT_W-1:0] = state_reg.cap1;
      tcc_pkg::OFS_COUNT:  rd_mux[tcc_pkg::CNT_W-1:0] = state_reg.count;
      default:             rd_mux = '0;
    endcase
  end

  // Count source, capture and match events. All but the status clear are
  // gated by the channel enable; a disabled channel only lets status reads clear bits.
  always_comb begin
    pre_run = state_reg.enable & state_reg.run_pre;
    cnt_src = 1'b0;
    unique case (state_reg.clksel)
      tcc_pkg::CLK_EXT: cnt_src = in0_rise; // RULE4
      tcc_pkg::CLK_PT1: cnt_src = &state_reg.pre[PT1_SHIFT-1:0];
      tcc_pkg::CLK_PT2: cnt_src = &state_reg.pre[PT2_SHIFT-1:0];
      tcc_pkg::CLK_PT3: cnt_src = &state_reg.pre[PT3_SHIFT-1:0];
    endcase
    cnt_tick = pre_run & state_reg.run_cnt & cnt_src; // RULE14 RULE16
    cap0_ev  = 1'b0;
    cap1_ev  = 1'b0;
    unique case (state_reg.capmode)
      tcc_pkg::CAP_OFF: begin
        cap0_ev = 1'b0;
      end
      tcc_pkg::CAP_RISE_BOTH: begin
        cap0_ev = in0_rise; // RULE2
        cap1_ev = in1_rise; // RULE6
      end
      tcc_pkg::CAP_IN0_PULSE: begin
        cap0_ev = in0_rise; // RULE5
        cap1_ev = in0_fall; // RULE5
      end
      tcc_pkg::CAP_COMPANION: begin
        cap0_ev = comp_rise; // RULE3
        cap1_ev = comp_fall; // RULE3
      end
    endcase
    cap0_ev = cap0_ev & state_reg.enable; // RULE16
    cap1_ev = cap1_ev & state_reg.enable; // RULE16
    // A match fires on the tick that brings the counter to the value.
    cnt_inc = state_reg.count + tcc_pkg::CNT_STEP;
    m0_ev   = cnt_tick & (cnt_inc == state_reg.cmp0);
    m1_ev   = cnt_tick & (cnt_inc == state_reg.cmp1); // RULE9
    ovf_ev  = cnt_tick & (state_reg.count == tcc_pkg::CNT_MAX);
    events               = '0;
    events[tcc_pkg::ST_M0]  = m0_ev;
    events[tcc_pkg::ST_M1]  = m1_ev;
    events[tcc_pkg::ST_OVF] = ovf_ev;
    events[tcc_pkg::ST_C0]  = cap0_ev; // RULE7
    events[tcc_pkg::ST_C1]  = cap1_ev; // RULE7
    // Simultaneous toggle causes give one inversion, not several.
    toggle_req = (m0_ev & state_reg.ff_en[tcc_pkg::EN_M0]) |  // RULE8
                 (m1_ev & state_reg.ff_en[tcc_pkg::EN_M1]) |  // RULE9
                 (cap0_ev & state_reg.ff_en[tcc_pkg::EN_C0]) | // RULE10
                 (cap1_ev & state_reg.ff_en[tcc_pkg::EN_C1]);
    st_clr = (rd_ok && avs_address == tcc_pkg::OFS_STATUS) ?
             rdata_reg[tcc_pkg::ST_W-1:0] : '0;
  end

  // Next state of the channel. A software write to the flip-flop wins
  // over a toggle in the same cycle; a status set wins over its clear.
  always_comb begin
    state_next = state_reg;
    if (pre_run) begin
      state_next.pre = state_reg.pre + tcc_pkg::PRE_STEP;
    end
    if (cnt_tick) begin
      state_next.count = cnt_inc; // RULE1 RULE17
    end
    if (cap0_ev) begin
      state_next.cap0 = state_reg.count; // RULE1
    end
    if (cap1_ev) begin
      state_next.cap1 = state_reg.count;
    end
    if (toggle_req) begin
      state_next.ff = ~state_reg.ff; // RULE12
    end
    state_next.status = (state_reg.status & ~st_clr) | events;
    if (wr_ok) begin
      case (avs_address)
        tcc_pkg::OFS_ENABLE: state_next.enable = wmerge[tcc_pkg::EN_BIT];
        tcc_pkg::OFS_RUN: begin
          state_next.run_cnt = wmerge[tcc_pkg::RUN_CNT_BIT]; // RULE14
          state_next.run_pre = wmerge[tcc_pkg::RUN_PRE_BIT]; // RULE14
        end
        tcc_pkg::OFS_MODE: begin
          state_next.clksel = tcc_pkg::tcc_clksel_t'(
            wmerge[tcc_pkg::CLK_LSB +: tcc_pkg::SEL_W]);
          state_next.capmode = tcc_pkg::tcc_capmode_t'(
            wmerge[tcc_pkg::CAP_LSB +: tcc_pkg::SEL_W]);
        end
        tcc_pkg::OFS_FFCR: begin
          state_next.ff_en =
            wmerge[tcc_pkg::FF_EN_LSB +: tcc_pkg::FF_EN_W]; // RULE12
        end
        tcc_pkg::OFS_MASK: state_next.mask = wmerge[tcc_pkg::ST_W-1:0];
        tcc_pkg::OFS_CMP0: state_next.cmp0 = wmerge[tcc_pkg::CNT_W-1:0];
        tcc_pkg::OFS_CMP1: state_next.cmp1 = wmerge[tcc_pkg::CNT_W-1:0];
        default: state_next.enable = state_reg.enable;
      endcase
    end
    if (ff_wr) begin
      unique case (ff_ctl)
        tcc_pkg::FF_INVERT: state_next.ff = ~state_reg.ff;
        tcc_pkg::FF_SET:    state_next.ff = 1'b1;
        tcc_pkg::FF_CLEAR:  state_next.ff = 1'b0; // RULE11
        tcc_pkg::FF_KEEP:   state_next.ff = state_reg.ff;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= tcc_pkg::REGS_RST;
      ack_reg   <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs: the pin follows the flip-flop, interrupts are unmasked
  // sticky bits. Mask bits are one to block a source.
  always_comb begin
    timer_output_pin = state_reg.ff;
    match_irq    = |(state_reg.status[tcc_pkg::ST_OVF:tcc_pkg::ST_M0] &
                     ~state_reg.mask[tcc_pkg::ST_OVF:tcc_pkg::ST_M0]); // RULE13
    capture0_irq = state_reg.status[tcc_pkg::ST_C0] &
                   ~state_reg.mask[tcc_pkg::ST_C0]; // RULE7
    capture1_irq = state_reg.status[tcc_pkg::ST_C1] &
                   ~state_reg.mask[tcc_pkg::ST_C1]; // RULE7
    irq          = match_irq | capture0_irq | capture1_irq;
  end

  // Checks on the channel behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  cap0_value_a: assert property ( // RULE2
    cap0_ev |=> state_reg.cap0 == $past(state_reg.count))
    else $error("capture register 0 did not take the count");

  count_kept_a: assert property ( // RULE1
    cap0_ev && !cnt_tick |=> $stable(state_reg.count))
    else $error("capture disturbed the counter");

  companion_cap_a: assert property ( // RULE3
    state_reg.enable && state_reg.capmode == tcc_pkg::CAP_COMPANION &&
    comp_fall |=> state_reg.cap1 == $past(state_reg.count))
    else $error("companion fall did not load capture register 1");

  event_count_a: assert property ( // RULE4
    state_reg.enable && state_reg.run_cnt && state_reg.run_pre &&
    state_reg.clksel == tcc_pkg::CLK_EXT && in0_rise
    |=> state_reg.count == $past(state_reg.count) + tcc_pkg::CNT_STEP)
    else $error("external edge was not counted");

  pulse_fall_a: assert property ( // RULE5
    state_reg.enable && state_reg.capmode == tcc_pkg::CAP_IN0_PULSE &&
    in0_fall |=> state_reg.cap1 == $past(state_reg.count))
    else $error("falling edge did not load capture register 1");

  time_diff_a: assert property ( // RULE6
    state_reg.enable && state_reg.capmode == tcc_pkg::CAP_RISE_BOTH &&
    in1_rise && !in0_rise
    |=> state_reg.cap1 == $past(state_reg.count) &&
        $stable(state_reg.cap0))
    else $error("input 1 capture wrong");

  cap_irq_a: assert property ( // RULE7
    cap1_ev && !state_reg.mask[tcc_pkg::ST_C1] |=> capture1_irq [*2])
    else $error("capture 1 interrupt missing");

  match_toggle_a: assert property ( // RULE8
    m0_ev && state_reg.ff_en[tcc_pkg::EN_M0] && !ff_wr
    |=> state_reg.ff != $past(state_reg.ff))
    else $error("compare 0 match did not invert the flip-flop");

  match1_toggle_a: assert property ( // RULE9
    cnt_tick && cnt_inc == state_reg.cmp1 &&
    state_reg.ff_en[tcc_pkg::EN_M1] && !ff_wr
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("compare 1 match did not invert the output");

  cap_toggle_a: assert property ( // RULE10
    cap0_ev && state_reg.ff_en[tcc_pkg::EN_C0] && !ff_wr
    |=> state_reg.ff != $past(state_reg.ff))
    else $error("capture 0 did not invert the flip-flop");

  ff_clear_a: assert property ( // RULE11
    ff_wr && ff_ctl == tcc_pkg::FF_CLEAR && wmerge[3:2] == 2'h0
    |=> !timer_output_pin && state_reg.ff_en[1:0] == 2'h0)
    else $error("clear write did not force the output low");

  no_toggle_a: assert property ( // RULE12
    !toggle_req && !ff_wr |=> $stable(state_reg.ff))
    else $error("flip-flop inverted without a cause");

  mask_gate_a: assert property ( // RULE13
    m1_ev && !state_reg.mask[tcc_pkg::ST_M1] |=> match_irq)
    else $error("unmasked compare 1 match gave no interrupt");

  stopped_a: assert property ( // RULE14
    !state_reg.run_cnt && !state_reg.run_pre |=> $stable(state_reg.count))
    else $error("counter moved while stopped");

  disabled_a: assert property ( // RULE16
    !state_reg.enable |=> $stable(state_reg.count) &&
    $stable(state_reg.cap0) && $stable(state_reg.cap1))
    else $error("disabled channel changed state");

  wrap_a: assert property ( // RULE17
    cnt_tick && state_reg.count == tcc_pkg::CNT_MAX
    |=> state_reg.count == '0 && state_reg.status[tcc_pkg::ST_OVF])
    else $error("counter did not wrap to zero");
endmodule

// File: verif/tcc_pulse_src.sv
/*
  Pulse source model for the capture pins of the timer channel.
  Assumes drive is called just after a rising sys_clk edge.
*/
`timescale 1ns/10ps
module tcc_pulse_src (
  input  wire logic sys_clk,         // System clock.
  output logic      capture_input0,  // Capture pin 0.
  output logic      capture_input1,  // Capture pin 1.
  output logic      companion_ff_in  // Companion flip-flop.
);
  logic [2:0] lines;
  assign {companion_ff_in, capture_input1, capture_input0} = lines;
  initial lines = 3'h0;
  // Raise line a; after gap cycles drop it (a equals b) or raise b.
  // Levels move only after an edge, so every gap is whole cycles.
  task automatic drive(input int a, input int b, input int gap);
    lines[a] <= 1'b1;
    repeat (gap) @(posedge sys_clk);
    if (a == b) lines[a] <= 1'b0;
    else lines[b] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    lines <= 3'h0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// File: verif/tb_top.sv
/*
  Self-checking bench of the timer channel over Avalon-MM.
  Assumes the pulse source model drives the capture pins.
*/
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_v, c0;
  logic [3:0]  avs_byteenable;
  logic        in0, in1, comp, pin, m_irq, c0_irq, c1_irq, irq;
  int          num_errors = 0;
  int          total_checks = 0;
  typedef struct {logic [5:0] a; logic [31:0] e;} tcc_rrow_t;
  typedef struct {logic [31:0] m; int a, b, g; logic [15:0] d;} tcc_crow_t;
  tcc_rrow_t rrows[6] = '{'{6'h00, 32'h0}, '{6'h08, 32'h0},
    '{6'h0C, 32'h3}, '{6'h14, 32'h1F}, '{6'h28, 32'h0}, '{6'h3C, 32'h0}};
  tcc_crow_t crows[3] = '{'{32'h0B, 0, 1, 64, 16'h2},
    '{32'h12, 0, 0, 32, 16'h4}, '{32'h19, 2, 2, 30, 16'hF}};

  tcc_timer dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_input0(in0), .capture_input1(in1), .companion_ff_in(comp),
    .timer_output_pin(pin), .match_irq(m_irq), .capture0_irq(c0_irq),
    .capture1_irq(c1_irq), .irq(irq));
  tcc_pulse_src src_u (.sys_clk(sys_clk), .capture_input0(in0),
    .capture_input1(in1), .companion_ff_in(comp));

  // Clock at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hang counts as a mismatch; the whole run needs about 460 cycles.
  initial begin
    repeat (8000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end
  // Main sequence: reset values, capture modes, compare and events.
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rrows[i]) begin
      bus(1'b0, rrows[i].a, 32'h0);
      chk("reset value", rd_v, rrows[i].e);
    end
    bus(1'b1, 6'h18, 32'h1234);
    bus(1'b0, 6'h18, 32'h0);
    chk("disabled write", rd_v, 32'h0);
    bus(1'b1, 6'h00, 32'h1);
    bus(1'b1, 6'h14, 32'h07);
    bus(1'b1, 6'h04, 32'h5);
    foreach (crows[i]) begin
      bus(1'b1, 6'h08, crows[i].m);
      src_u.drive(crows[i].a, crows[i].b, crows[i].g);
      bus(1'b0, 6'h20, 32'h0);
      c0 = rd_v;
      bus(1'b0, 6'h24, 32'h0);
      chk("capture diff", {16'h0, rd_v[15:0] - c0[15:0]},
          {16'h0, crows[i].d});
      chk("capture irqs", {c0_irq, c1_irq, irq}, 3'h7);
      bus(1'b0, 6'h10, 32'h0);
      chk("capture status", rd_v & 32'h18, 32'h18);
      // The clear lands on the completing edge, so look one edge later.
      @(posedge sys_clk);
      chk("irq cleared", {c0_irq, c1_irq}, 2'h0);
    end
    bus(1'b1, 6'h04, 32'h0);
    bus(1'b0, 6'h28, 32'h0);
    c0 = rd_v;
    bus(1'b0, 6'h28, 32'h0);
    chk("stopped count", rd_v, c0);
    bus(1'b1, 6'h1C, c0 + 32'h14);
    bus(1'b1, 6'h18, c0 + 32'h5);
    bus(1'b1, 6'h0C, 32'h0D);
    @(posedge sys_clk);
    chk("pin set", pin, 1'b1);
    bus(1'b1, 6'h0C, 32'h0E);
    @(posedge sys_clk);
    chk("pin cleared", pin, 1'b0);
    // One tick per two cycles: compare 0 falls near 10, compare 1 near 40.
    bus(1'b1, 6'h04, 32'h5);
    repeat (20) @(posedge sys_clk);
    chk("match0 toggle", pin, 1'b1);
    repeat (30) @(posedge sys_clk);
    chk("match1 toggle", pin, 1'b0);
    chk("masked match", m_irq, 1'b0);
    bus(1'b1, 6'h14, 32'h05);
    @(posedge sys_clk);
    chk("unmasked match", m_irq, 1'b1);
    // Invert once with both enables off; the next compare 1 match must
    // leave the pin alone.
    bus(1'b1, 6'h0C, 32'h00);
    bus(1'b1, 6'h1C, c0 + 32'h40);
    repeat (80) @(posedge sys_clk);
    chk("no match toggle", pin, 1'b1);
    bus(1'b1, 6'h0C, 32'h02);
    @(posedge sys_clk);
    chk("forced clear", pin, 1'b0);
    bus(1'b1, 6'h0C, 32'h13);
    bus(1'b1, 6'h08, 32'h09);
    src_u.drive(0, 0, 2);
    chk("capture toggle", pin, 1'b1);
    bus(1'b1, 6'h08, 32'h00);
    bus(1'b0, 6'h28, 32'h0);
    c0 = rd_v;
    repeat (3) src_u.drive(0, 0, 2);
    bus(1'b0, 6'h28, 32'h0);
    chk("event count", rd_v - c0, 32'h3);
    // Reset in mid-run: the pin was high and the channel was running.
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk("reset pin", pin, 1'b0);
    bus(1'b0, 6'h04, 32'h0);
    chk("reset run", rd_v, 32'h0);
    finish_test();
  end
endmodule
